// >>> rtl/rpc_port_flags.sv
`timescale 1ns/1ns
// Functional notes
// - Resume change set after 20ms, EOP, 3ms
// - Write one clears resume change; reset-done clears
// - Hardware enable loss sets enable change
// - Software enable changes never set it
// - Connect edges set connect change; W1C
// - Set commands while disconnected set connect change
// - Non-removable port: connect edges ignored; change set once after reset
// - Bit 9 reads slow device speed
// - Writing one to bit 9 removes power
// - Reset change set after 10ms reset
// - Status writes deferred during bus transaction
module rpc_port_flags
  import rpc_pkg::*;
#(
  parameter int RESUME_CYC = RPC_RESUME_CYC,    // Resume pulse length
  parameter int RESYNC_CYC = RPC_RESYNC_CYC,    // Resync delay
  parameter int PRST_CYC   = RPC_PORT_RESET_CYC // Port reset length
) (
  input  wire logic              sys_clk_i,     // System clock
  input  wire logic              rst_b_i,       // Sync reset, active low
  input  wire logic              clk_en_i,      // Freezes state when low
  input  wire rpc_pkg::rpc_bus_s bus_i,         // Register bus request
  output logic [31:0]            rd_data_o,     // Read data, cycle after read
  input  wire logic              connect_i,     // Device present pin
  input  wire logic              slow_i,        // Low-speed line state pin
  input  wire logic              port_error_i,  // Hardware disable event pin
  input  wire logic              remote_wake_i, // Device resume request pin
  input  wire logic              busy_i,        // Transaction in progress
  input  wire logic              non_removable_i, // Device fixed on port
  output logic                   port_power_o,  // Port power switch
  output logic                   port_reset_o,  // Reset signalling active
  output logic                   resume_o,      // Resume signalling active
  output logic                   irq_o          // Level interrupt
);
  import rpc_pkg::*;

  // Refuse phase lengths the shared timer cannot count; their end compare is cut to RPC_CNT_W bits
  if (RESUME_CYC < 1 || RESYNC_CYC < 1 || PRST_CYC < 1 ||
      RESUME_CYC >= (1 << RPC_CNT_W) || RESYNC_CYC >= (1 << RPC_CNT_W) ||
      PRST_CYC >= (1 << RPC_CNT_W)) begin : g_bad_count
    $error("rpc_port_flags: count out of range");
  end

  // Whole module state
  typedef struct packed {
    logic [2:0]       conn_s;      // Connect synchroniser
    logic [2:0]       slow_s;      // Speed synchroniser
    logic [2:0]       err_s;       // Error synchroniser
    logic [2:0]       wake_s;      // Wake synchroniser
    logic             conn;        // Filtered connect status
    logic             slow;        // Filtered speed
    logic             err_q;       // Filtered error level
    logic             wake_q;      // Filtered wake level
    logic             enabled;     // Port enabled
    logic             suspended;   // Port suspended
    logic             powered;     // Port powered
    logic             conn_chg;    // Connect change
    logic             en_chg;      // Enable change
    logic             resume_chg;  // Resume done change
    logic             reset_chg;   // Reset done change
    logic             pend;        // Deferred write waiting
    logic [31:0]      pend_data;   // Deferred write data
    logic             boot_rpt;    // Post-reset attach report due
    rpc_state_e       state;       // Sequencer
    logic [RPC_CNT_W-1:0] cnt;     // Sequencer timer
    logic [3:0]       mask;        // Interrupt mask
    logic [3:0]       irq_stat;    // Sticky event bits
    logic [31:0]      rd_data;     // Read data register
    logic             irq;         // Interrupt output
    logic             prst_q;      // Reset signalling output flop
    logic             resume_q;    // Resume signalling output flop
  } rpc_state_s;

  rpc_state_s st;
  rpc_state_s next_st;
  logic [31:0] status_word;        // Readable port word

  // Assemble readable word; reserved bits stay zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[RPC_BIT_CONNECT]    = st.conn;
    status_word[RPC_BIT_ENABLED]    = st.enabled;
    status_word[RPC_BIT_SUSPEND]    = st.suspended;
    status_word[RPC_BIT_RESET]      = (st.state == RPC_PRST);
    status_word[RPC_BIT_POWERED]    = st.powered;
    status_word[RPC_BIT_SLOW]       = st.slow;
    status_word[RPC_BIT_CONN_CHG]   = st.conn_chg;
    status_word[RPC_BIT_EN_CHG]     = st.en_chg;
    status_word[RPC_BIT_RESUME_CHG] = st.resume_chg;
    status_word[RPC_BIT_RESET_CHG]  = st.reset_chg;
    status_word = status_word & RPC_READ_MASK;
  end

  // Next-state logic
  always_comb begin
    logic        do_wr;   // Status write applied this cycle
    logic [31:0] wd;      // Applied write data
    logic        conn_edge;
    logic        ev_conn;
    logic        ev_en;
    logic        ev_res;
    logic        ev_rst;
    do_wr = 1'b0;
    wd = 32'h0000_0000;
    conn_edge = 1'b0;
    ev_conn = 1'b0;
    ev_en = 1'b0;
    ev_res = 1'b0;
    ev_rst = 1'b0;
    next_st = st;
    if (clk_en_i) begin
      // Three-stage pin synchronisers
      next_st.conn_s = {st.conn_s[1:0], connect_i};
      next_st.slow_s = {st.slow_s[1:0], slow_i};
      next_st.err_s  = {st.err_s[1:0], port_error_i};
      next_st.wake_s = {st.wake_s[1:0], remote_wake_i};
      // Accept a level once stages two and three agree
      if (st.conn_s[1] == st.conn_s[2]) next_st.conn = st.conn_s[2];
      if (st.slow_s[1] == st.slow_s[2]) next_st.slow = st.slow_s[2];
      if (st.err_s[1] == st.err_s[2]) next_st.err_q = st.err_s[2];
      if (st.wake_s[1] == st.wake_s[2]) next_st.wake_q = st.wake_s[2];
      conn_edge = (next_st.conn != st.conn);

      // Status writes wait for the bus transaction to finish
      if (bus_i.wr && bus_i.addr == RPC_ADDR_STATUS) begin
        if (busy_i) begin
          next_st.pend = 1'b1;
          next_st.pend_data = bus_i.wdata;
        end else begin
          do_wr = 1'b1;
          wd = bus_i.wdata;
        end
      end else if (st.pend && !busy_i) begin
        do_wr = 1'b1;
        wd = st.pend_data;
        next_st.pend = 1'b0;
      end
      if (bus_i.wr && bus_i.addr == RPC_ADDR_IRQ_MASK) next_st.mask = bus_i.wdata[3:0];

      // Line events
      if (conn_edge && !non_removable_i) ev_conn = 1'b1;
      if (st.boot_rpt && st.conn && non_removable_i) begin
        ev_conn = 1'b1;
        next_st.boot_rpt = 1'b0;
      end
      if (!next_st.conn) begin
        next_st.enabled = 1'b0;
        next_st.suspended = 1'b0;
        if (st.enabled) ev_en = 1'b1;
      end
      if (next_st.err_q && !st.err_q && st.enabled) begin
        next_st.enabled = 1'b0;
        ev_en = 1'b1;
      end
      if (next_st.wake_q && !st.wake_q && st.suspended && st.state == RPC_IDLE) begin
        next_st.state = RPC_RESUME;
        next_st.cnt = '0;
      end

      // Software commands; bit 3 clears suspend, other reserved bits have no decode
      if (do_wr) begin
        if (wd[RPC_BIT_CONN_CHG]) next_st.conn_chg = 1'b0;
        if (wd[RPC_BIT_EN_CHG]) next_st.en_chg = 1'b0;
        if (wd[RPC_BIT_RESUME_CHG]) next_st.resume_chg = 1'b0;
        if (wd[RPC_BIT_RESET_CHG]) next_st.reset_chg = 1'b0;
        if (wd[RPC_BIT_POWERED]) next_st.powered = 1'b1;
        if (wd[RPC_BIT_SLOW]) begin
          next_st.powered = 1'b0;
          next_st.enabled = 1'b0;
          next_st.suspended = 1'b0;
        end
        if (wd[RPC_BIT_CONNECT]) next_st.enabled = 1'b0;
        if (wd[RPC_BIT_ENABLED] || wd[RPC_BIT_SUSPEND] || wd[RPC_BIT_RESET]) begin
          if (!st.conn) ev_conn = 1'b1;
          else begin
            if (wd[RPC_BIT_ENABLED]) next_st.enabled = 1'b1;
            if (wd[RPC_BIT_SUSPEND] && st.enabled) next_st.suspended = 1'b1;
            if (wd[RPC_BIT_RESET] && st.state == RPC_IDLE) begin
              next_st.state = RPC_PRST;
              next_st.cnt = '0;
            end
          end
        end
        if (wd[RPC_BIT_SUSPEND + 1] && st.suspended && st.state == RPC_IDLE) begin
          next_st.state = RPC_RESUME;                           // Clear-suspend starts resume
          next_st.cnt = '0;
        end
      end

      // Resume and port reset sequencer
      case (st.state)
        RPC_IDLE: begin
        end
        RPC_RESUME: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == RPC_CNT_W'(RESUME_CYC - 1)) begin
            next_st.state = RPC_EOP;
            next_st.cnt = '0;
          end
        end
        RPC_EOP: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == RPC_CNT_W'(RPC_EOP_CYC - 1)) begin
            next_st.state = RPC_RESYNC;
            next_st.cnt = '0;
          end
        end
        RPC_RESYNC: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == RPC_CNT_W'(RESYNC_CYC - 1)) begin
            next_st.state = RPC_IDLE;
            next_st.suspended = 1'b0;
            ev_res = 1'b1;
          end
        end
        RPC_PRST: begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == RPC_CNT_W'(PRST_CYC - 1)) begin
            next_st.state = RPC_IDLE;
            next_st.enabled = st.conn;
            ev_rst = 1'b1;
          end
        end
        default: next_st.state = RPC_IDLE;
      endcase
      // Losing power or link aborts any sequence
      if (!next_st.powered || !next_st.conn) begin
        if (st.state != RPC_IDLE) next_st.state = RPC_IDLE;
        next_st.suspended = 1'b0;
        next_st.enabled = 1'b0;
      end

      // Sets win over same-cycle clears
      if (ev_conn) next_st.conn_chg = 1'b1;
      if (ev_en) next_st.en_chg = 1'b1;
      if (ev_rst) begin
        next_st.reset_chg = 1'b1;
        next_st.resume_chg = 1'b0;
      end else if (ev_res) next_st.resume_chg = 1'b1;

      // Interrupt status: read clears, events win
      if (bus_i.rd && bus_i.addr == RPC_ADDR_IRQ_MASK + 8'h04) next_st.irq_stat = 4'h0;
      next_st.irq_stat = next_st.irq_stat | {ev_rst, ev_res, ev_en, ev_conn};
      next_st.irq = |(next_st.irq_stat & next_st.mask);
      // Resume and port reset phases leave the block through their own flops
      next_st.prst_q   = (next_st.state == RPC_PRST);
      next_st.resume_q = (next_st.state == RPC_RESUME);

      // Read data stands one cycle
      next_st.rd_data = 32'h0000_0000;
      if (bus_i.rd) begin
        case (bus_i.addr)
          RPC_ADDR_STATUS:           next_st.rd_data = status_word;
          RPC_ADDR_IRQ_MASK:         next_st.rd_data = {28'h0, st.mask};
          RPC_ADDR_IRQ_MASK + 8'h04: next_st.rd_data = {28'h0, st.irq_stat};
          default:                   next_st.rd_data = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.powered <= 1'b1;
      st.boot_rpt <= 1'b1;
      st.mask <= RPC_MASK_RESET;
      st.state <= RPC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o    = st.rd_data;
  assign port_power_o = st.powered;
  assign port_reset_o = st.prst_q;
  assign resume_o     = st.resume_q;
  assign irq_o        = st.irq;

  // Resume change only after the full sequence
  sequence resync_end_s;
    st.state == RPC_RESYNC && clk_en_i && st.cnt == RPC_CNT_W'(RESYNC_CYC - 1);
  endsequence
  resume_done_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(st.resume_chg) |-> $past(st.state) == RPC_RESYNC)
    else $error("resume change set outside resync end");
  reset_clears_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(st.reset_chg) |-> !st.resume_chg)
    else $error("resume change survives reset done");
  en_chg_cause_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(st.en_chg) |-> $past(st.enabled) && !st.enabled)
    else $error("enable change without enable loss");
  en_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (st.en_chg && !next_st.en_chg) |-> clk_en_i && (bus_i.wr || st.pend))
    else $error("enable change cleared without write");
  conn_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (clk_en_i && st.conn != next_st.conn && !non_removable_i) |=> st.conn_chg)
    else $error("connect edge missed");
  slow_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (clk_en_i && bus_i.rd && bus_i.addr == RPC_ADDR_STATUS) |=> rd_data_o[RPC_BIT_SLOW] == $past(st.slow))
    else $error("speed bit mismatch");
  reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (clk_en_i && bus_i.rd && bus_i.addr == RPC_ADDR_STATUS)
    |=> (rd_data_o & ~RPC_READ_MASK) == 32'h0)
    else $error("reserved bits nonzero");
  defer_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (clk_en_i && busy_i && bus_i.wr && bus_i.addr == RPC_ADDR_STATUS && bus_i.wdata[RPC_BIT_SLOW]
     && st.powered && !st.pend) |=> st.powered && st.pend)
    else $error("write applied during transaction");
  resume_seq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    resync_end_s |=> st.resume_chg)
    else $error("resume sequence end bad");
endmodule // rpc_port_flags

// >>> shared/rpc_pkg.sv
package rpc_pkg;
  // Register word address (index 0); interrupt mask at 0x04, interrupt status at 0x08
  localparam logic [7:0] RPC_ADDR_STATUS   = 8'h00;
  localparam logic [7:0] RPC_ADDR_IRQ_MASK = 8'h04;
  // Field positions in the port status word
  localparam int RPC_BIT_CONNECT      = 0;
  localparam int RPC_BIT_ENABLED      = 1;
  localparam int RPC_BIT_SUSPEND      = 2;
  localparam int RPC_BIT_RESET        = 4;
  localparam int RPC_BIT_POWERED      = 8;
  localparam int RPC_BIT_SLOW         = 9;
  localparam int RPC_BIT_CONN_CHG     = 16;
  localparam int RPC_BIT_EN_CHG       = 17;
  localparam int RPC_BIT_RESUME_CHG   = 18;
  localparam int RPC_BIT_RESET_CHG    = 20;
  // Readable field mask; write-only bit 3 and reserved bits read zero
  localparam logic [31:0] RPC_READ_MASK = 32'h0017_0317;
  // Reset value of the interrupt mask
  localparam logic [3:0] RPC_MASK_RESET = 4'h0;
  // Timing
  localparam int RPC_CLK_HZ          = 50_000_000;
  localparam int RPC_RESUME_MS       = 20;
  localparam int RPC_RESYNC_MS       = 3;
  localparam int RPC_PORT_RESET_MS   = 10;
  localparam int RPC_RESUME_CYC      = RPC_CLK_HZ / 1000 * RPC_RESUME_MS;
  localparam int RPC_RESYNC_CYC      = RPC_CLK_HZ / 1000 * RPC_RESYNC_MS;
  localparam int RPC_PORT_RESET_CYC  = RPC_CLK_HZ / 1000 * RPC_PORT_RESET_MS;
  localparam int RPC_EOP_CYC         = 2;
  localparam int RPC_CNT_W           = 20;

  // Sequencer states
  typedef enum logic [2:0] {
    RPC_IDLE   = 3'b000,
    RPC_RESUME = 3'b001,
    RPC_EOP    = 3'b010,
    RPC_RESYNC = 3'b011,
    RPC_PRST   = 3'b100
  } rpc_state_e;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rpc_bus_s;

  // Port-side line events
  typedef struct packed {
    logic connect;
    logic slow;
    logic port_error;
    logic remote_wake;
    logic busy;
  } rpc_line_s;
endpackage

// >>> testbench/rpc_usb_dev_model.sv
`timescale 1ns/1ns
// Downstream device as seen on the port lines. It needs no clock: the block
// passes every line except busy through its own synchroniser before using it.
module rpc_usb_dev_model (
  input  wire logic attach_i,      // Device plugged in
  input  wire logic low_speed_i,   // Device signals low speed
  input  wire logic fault_i,       // Force a line fault
  input  wire logic wake_i,        // Drive resume signalling
  input  wire logic busy_i,        // Hold a transaction open
  output logic      connect_o,     // Presence at the port
  output logic      slow_o,        // Low-speed idle state
  output logic      port_error_o,  // Fault seen by the port
  output logic      remote_wake_o, // Resume seen by the port
  output logic      busy_o         // Transaction in flight
);
  // Detached lines fall to the pull-down level, so no stale state survives
  assign connect_o     = attach_i;
  assign slow_o        = attach_i & low_speed_i;
  assign port_error_o  = attach_i & fault_i;
  assign remote_wake_o = attach_i & wake_i;
  assign busy_o        = attach_i & busy_i;
endmodule // rpc_usb_dev_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
// Register-level bench for the port change flags
module tb_top;
  import rpc_pkg::*;
  localparam int         RES_C = 20;    // Shortened resume pulse
  localparam int         SYN_C = 5;     // Shortened resync delay
  localparam int         PRS_C = 10;    // Shortened port reset
  localparam int         LIMIT = 5000;  // Whole run needs well under this
  localparam logic [7:0] IRQ_A = 8'h08; // Interrupt status, read clears
  logic        sys_clk_i, rst_b_i, non_rem; // Clock, reset, fixed device
  logic        clk_en;                      // Block clock enable
  rpc_bus_s    bus;                         // Register bus request
  logic [31:0] rd_data, d;                  // Read data and last word read
  logic        att, low, flt, wak, bsy;     // Device model controls
  logic        conn_w, slow_w, err_w, wake_w, busy_w;
  logic        pwr, prst, res, irq;         // Block outputs
  int          mismatches, samples_checked, cyc;

  rpc_usb_dev_model rpc_usb_dev_model_inst (.attach_i(att), .low_speed_i(low),
    .fault_i(flt), .wake_i(wak), .busy_i(bsy), .connect_o(conn_w), .slow_o(slow_w),
    .port_error_o(err_w), .remote_wake_o(wake_w), .busy_o(busy_w));

  rpc_port_flags #(.RESUME_CYC(RES_C), .RESYNC_CYC(SYN_C), .PRST_CYC(PRS_C))
    rpc_port_flags_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
    .bus_i(bus), .rd_data_o(rd_data), .connect_i(conn_w), .slow_i(slow_w),
    .port_error_i(err_w), .remote_wake_i(wake_w), .busy_i(busy_w),
    .non_removable_i(non_rem), .port_power_o(pwr), .port_reset_o(prst),
    .resume_o(res), .irq_o(irq));

  // Free-running 50 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data only stands in the following cycle, so it is
  // taken at the edge that closes that cycle, before the block updates it
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus.rd <= 1'b0;
    @(posedge sys_clk_i);
    v = rd_data;
  endtask

  // Read the port status and compare the masked bits
  task automatic sts(input logic [31:0] m, input logic [31:0] e);
    rd(RPC_ADDR_STATUS, d);
    check(d & m, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks: %0d, mismatches: %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    {rst_b_i, non_rem, att, low, flt, wak, bsy} = '0;
    clk_en = 1'b1;
    bus = '0;
    {mismatches, samples_checked, cyc} = '0;
    wait_cyc(8);
    rst_b_i <= 1'b1;
    sts(32'hFFFF_FFFF, 32'h0000_0100);
    rd(8'h0C, d);
    check(d, 32'h0000_0000);
    rd(RPC_ADDR_IRQ_MASK, d);
    check(d, {28'h0, RPC_MASK_RESET});
    wr(RPC_ADDR_IRQ_MASK, 32'h0000_000F);
    // Low-speed device arrives
    att <= 1'b1;
    low <= 1'b1;
    wait_cyc(10);
    sts(32'hFFFF_FFFF, 32'h0001_0301);
    check(32'(irq), 32'h1);
    rd(IRQ_A, d);
    check(d, 32'h0000_0001);
    rd(IRQ_A, d);
    check(d, 32'h0000_0000);
    wait_cyc(3);
    check(32'(irq), 32'h0);
    // Zero writes and reserved bits leave everything alone
    wr(RPC_ADDR_STATUS, 32'h0000_0000);
    sts(32'hFFFF_FFFF, 32'h0001_0301);
    wr(RPC_ADDR_STATUS, 32'hFFE0_FC00);
    sts(32'hFFFF_FFFF, 32'h0001_0301);
    wr(RPC_ADDR_STATUS, 32'h0001_0000);
    sts(32'hFFFF_FFFF, 32'h0000_0301);
    // Software enable and disable never flag a change
    wr(RPC_ADDR_STATUS, 32'h0000_0002);
    sts(32'hFFFF_FFFF, 32'h0000_0303);
    wr(RPC_ADDR_STATUS, 32'h0000_0001);
    sts(32'hFFFF_FFFF, 32'h0000_0301);
    // A line fault drops the enable and flags it
    wr(RPC_ADDR_STATUS, 32'h0000_0002);
    flt <= 1'b1;
    wait_cyc(6);
    flt <= 1'b0;
    wait_cyc(6);
    sts(32'hFFFF_FFFF, 32'h0002_0301);
    rd(IRQ_A, d);
    check(d, 32'h0000_0002);
    wr(RPC_ADDR_STATUS, 32'h0002_0000);
    sts(32'hFFFF_FFFF, 32'h0000_0301);
    // Suspend, then the device wakes the port
    wr(RPC_ADDR_STATUS, 32'h0000_0002);
    wr(RPC_ADDR_STATUS, 32'h0000_0004);
    wak <= 1'b1;
    wait_cyc(6);
    wak <= 1'b0;
    wait_cyc(9);
    check(32'(res), 32'h1);
    sts(32'h0004_0000, 32'h0000_0000);
    wait_cyc(RES_C + SYN_C);
    sts(32'h0004_0000, 32'h0004_0000);
    wr(RPC_ADDR_STATUS, 32'h0000_0000);
    sts(32'h0004_0000, 32'h0004_0000);
    wr(RPC_ADDR_STATUS, 32'h0004_0000);
    sts(32'h0004_0000, 32'h0000_0000);
    // Clear-suspend command starts the same resume sequence
    wr(RPC_ADDR_STATUS, 32'h0000_0004);
    wr(RPC_ADDR_STATUS, 32'h0000_0008);
    wait_cyc(RES_C + SYN_C + 6);
    sts(32'h0004_0000, 32'h0004_0000);
    // Port reset completion also removes the resume flag
    wr(RPC_ADDR_STATUS, 32'h0000_0010);
    wait_cyc(1);
    check(32'(prst), 32'h1);
    wait_cyc(PRS_C + 8);
    sts(32'h0014_0000, 32'h0010_0000);
    wr(RPC_ADDR_STATUS, 32'h0010_0000);
    sts(32'h0010_0000, 32'h0000_0000);
    // Power removal waits for the open transaction
    bsy <= 1'b1;
    wr(RPC_ADDR_STATUS, 32'h0000_0200);
    wait_cyc(4);
    check(32'(pwr), 32'h1);
    bsy <= 1'b0;
    wait_cyc(4);
    check(32'(pwr), 32'h0);
    sts(32'h0000_0100, 32'h0000_0000);
    wr(RPC_ADDR_STATUS, 32'h0000_0100);
    sts(32'h0000_0100, 32'h0000_0100);
    wr(RPC_ADDR_STATUS, 32'h0017_0000);
    // Unplug; the speed bit is not judged while disconnected
    att <= 1'b0;
    wait_cyc(10);
    sts(32'h0001_0001, 32'h0001_0000);
    for (int i = 1; i <= 4; i++) begin
      if (i != 3) begin
        wr(RPC_ADDR_STATUS, 32'h0001_0000);
        wr(RPC_ADDR_STATUS, 32'h1 << i);
        sts(32'h0001_0000, 32'h0001_0000);
      end
    end
    // Fixed full-speed device: one change flag after reset, edges ignored
    rst_b_i <= 1'b0;
    non_rem <= 1'b1;
    att <= 1'b1;
    low <= 1'b0;
    wait_cyc(8);
    rst_b_i <= 1'b1;
    wait_cyc(10);
    sts(32'h0001_0201, 32'h0001_0001);
    // A write while the clock enable is low must be lost
    clk_en <= 1'b0;
    wr(RPC_ADDR_STATUS, 32'h0001_0000);
    clk_en <= 1'b1;
    sts(32'h0001_0000, 32'h0001_0000);
    wr(RPC_ADDR_STATUS, 32'h0001_0000);
    att <= 1'b0;
    wait_cyc(10);
    att <= 1'b1;
    wait_cyc(10);
    sts(32'h0001_0000, 32'h0000_0000);
    stop_test();
  end
endmodule // tb_top
